// >>> verilog/llp_pkg.sv
// Package: constants and types for the lead/lag pump staging sequencer
package llp_pkg;
   localparam int MAX_AUX_RELAY = 3;
   localparam int MAX_AUX_LINK  = 5;
   localparam int AUX_W         = 3;
   localparam int VAL_W         = 16;
   localparam int TMR_W         = 24;
   localparam int DRV_W         = 6;
   localparam int RELAY_W       = 3;

   localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
   localparam logic [31:0] ADDR_TARGET   = 32'h0000_0004;
   localparam logic [31:0] ADDR_STG_OFS  = 32'h0000_0008;
   localparam logic [31:0] ADDR_DST_OFS  = 32'h0000_000C;
   localparam logic [31:0] ADDR_STG_WAIT = 32'h0000_0010;
   localparam logic [31:0] ADDR_DST_WAIT = 32'h0000_0014;
   localparam logic [31:0] ADDR_MIN_SPD  = 32'h0000_0018;
   localparam logic [31:0] ADDR_DST_WIN  = 32'h0000_001C;
   localparam logic [31:0] ADDR_BOOST    = 32'h0000_0020;
   localparam logic [31:0] ADDR_HOLD     = 32'h0000_0024;
   localparam logic [31:0] ADDR_ROT      = 32'h0000_0028;
   localparam logic [31:0] ADDR_FILL     = 32'h0000_002C;
   localparam logic [31:0] ADDR_STATUS   = 32'h0000_0030;
   localparam logic [31:0] ADDR_PV       = 32'h0000_0034;

   // CTRL fields
   localparam int CTRL_AUX_LSB  = 0;
   localparam int CTRL_MUX_BIT  = 4;
   localparam int CTRL_LINK_BIT = 5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {
      LLP_RUN,
      LLP_BOOST
   } llp_state_t;

   typedef struct packed {
      logic [VAL_W-1:0] speedCmd;
      logic             speedOverride;
      logic [DRV_W-1:0] runCmd;
   } llp_drive_t;
endpackage : llp_pkg

// >>> verilog/llp_staging.sv
// Lead/lag and multiplex pump staging sequencer with AXI4-Lite registers
// Behaviour
// RULE1: Staging enabled only when aux count nonzero
// RULE2: At most three auxiliary pumps on relays
// RULE3: Staging active overrides other relay functions
// RULE4: Request auxiliaries in ascending relay order
// RULE5: Stage when value falls to target minus offset
// RULE6: Stage only after stage wait expires
// RULE7: Destage first opens the removed pump relay
// RULE8: After destage, master speed is min plus boost
// RULE9: Hold boost for hold time, then resume
// RULE10: Destage when value rises to target plus offset
// RULE11: Destage only after destage wait expires
// RULE12: Destage only while master speed in window
// RULE13: Primary staged first, destaged last, decides
// RULE14: Primary requests secondary by its run command
// RULE15: Multiplex: five over link, three over relays
// RULE16: Rotation needs nonzero count and period
// RULE17: Relays assigned to auxiliaries from relay one
// RULE18: Primary role rotates each rotation period
// RULE19: Master is second when auxiliary primary
// RULE20: Order k, master, then cyclic after k
// RULE21: Primary ignores stage wait, stages immediately
// RULE22: Fill pressure limit set below target
// RULE23: Destage in reverse of staging order
// RULE24: Wait timers restart when condition lapses
`timescale 1ns/1ps
`default_nettype none
module llp_staging
   import llp_pkg::*;
#(
   parameter int ROT_CYCLES_PER_UNIT = 1
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic [VAL_W-1:0]     processValue,
   input  wire logic [VAL_W-1:0]     masterSpeed,
   input  wire logic [RELAY_W-1:0]   relayFuncIn,
   output var  logic [RELAY_W-1:0]   relayOut,
   output var  llp_drive_t           drive,
   output var  logic                 masterRun,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_awaddr,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   output var  logic [1:0]           s_axi_bresp,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   input  wire logic [31:0]          s_axi_araddr,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp
);
   // ---------------------------------------------------------------
   // Pin synchronisers for the process value and speed feedback
   // ---------------------------------------------------------------
   logic [VAL_W-1:0] pvS1, pvS2, pvS3, pv;
   logic [VAL_W-1:0] spS1, spS2, spS3, spd;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pvS1 <= '0;
         pvS2 <= '0;
         pvS3 <= '0;
         pv   <= '0;
         spS1 <= '0;
         spS2 <= '0;
         spS3 <= '0;
         spd  <= '0;
      end else begin
         pvS1 <= processValue;
         pvS2 <= pvS1;
         pvS3 <= pvS2;
         spS1 <= masterSpeed;
         spS2 <= spS1;
         spS3 <= spS2;
         // Only a word seen twice in a row is taken, so skew is filtered
         if (pvS2 == pvS3) pv <= pvS3;
         if (spS2 == spS3) spd <= spS3;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [AUX_W-1:0] auxCount;
   logic             muxMode, linkMode;
   logic [VAL_W-1:0] target, stgOfs, dstOfs, minSpd, dstWin, boost, fillLim;
   logic [TMR_W-1:0] stgWait, dstWait, holdTime, rotPeriod;

   logic             awHeld, wHeld;
   logic [31:0]      awAddr, wData;
   logic [3:0]       wStrb;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      return r;
   endfunction : merge

   function automatic logic mapped(input logic [31:0] a);
      return (a[1:0] == 2'h0) && (a <= ADDR_PV);
   endfunction : mapped

   wire doWrite = awHeld && wHeld && !s_axi_bvalid;
   logic [31:0] ctrlWord;
   assign ctrlWord = {26'h0, linkMode, muxMode, 1'b0, auxCount};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= '0;
         wData         <= '0;
         wStrb         <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awAddr) && awAddr != ADDR_STATUS && awAddr != ADDR_PV
                           ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Lanes not strobed keep the register's present contents
   logic [31:0] wrWord;
   always_comb begin
      wrWord = merge(regRead(awAddr), wData, wStrb);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         auxCount  <= '0;
         muxMode   <= 1'b0;
         linkMode  <= 1'b0;
         target    <= '0;
         stgOfs    <= '0;
         dstOfs    <= '0;
         minSpd    <= '0;
         dstWin    <= '0;
         boost     <= '0;
         fillLim   <= '0;
         stgWait   <= '0;
         dstWait   <= '0;
         holdTime  <= '0;
         rotPeriod <= '0;
      end else if (doWrite) begin
         unique case (awAddr)
            ADDR_CTRL: begin
               auxCount <= wrWord[CTRL_AUX_LSB +: AUX_W];
               muxMode  <= wrWord[CTRL_MUX_BIT];
               linkMode <= wrWord[CTRL_LINK_BIT];
            end
            ADDR_TARGET:   target    <= wrWord[VAL_W-1:0];
            ADDR_STG_OFS:  stgOfs    <= wrWord[VAL_W-1:0];
            ADDR_DST_OFS:  dstOfs    <= wrWord[VAL_W-1:0];
            ADDR_STG_WAIT: stgWait   <= wrWord[TMR_W-1:0];
            ADDR_DST_WAIT: dstWait   <= wrWord[TMR_W-1:0];
            ADDR_MIN_SPD:  minSpd    <= wrWord[VAL_W-1:0];
            ADDR_DST_WIN:  dstWin    <= wrWord[VAL_W-1:0];
            ADDR_BOOST:    boost     <= wrWord[VAL_W-1:0];
            ADDR_HOLD:     holdTime  <= wrWord[TMR_W-1:0];
            ADDR_ROT:      rotPeriod <= wrWord[TMR_W-1:0];
            ADDR_FILL:     fillLim   <= wrWord[VAL_W-1:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Effective configuration
   // ---------------------------------------------------------------
   logic [AUX_W-1:0] auxEff;
   logic             staging, rotating;
   // Relays carry three units; the link five, in multiplex mode only
   assign auxEff = (!linkMode || !muxMode) ? ((auxCount > AUX_W'(MAX_AUX_RELAY)) ? // RULE2 RULE15
                   AUX_W'(MAX_AUX_RELAY) : auxCount)
                 : ((auxCount > AUX_W'(MAX_AUX_LINK)) ? AUX_W'(MAX_AUX_LINK) : auxCount);
   assign staging  = auxEff != '0; // RULE1
   assign rotating = staging && muxMode && rotPeriod != '0; // RULE16

   // ---------------------------------------------------------------
   // Primary rotation
   // ---------------------------------------------------------------
   logic [AUX_W-1:0] primary;   // 0 = master, k = auxiliary k
   logic [TMR_W-1:0] rotCnt;
   logic [15:0]      rotPre;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         primary <= '0; rotCnt <= '0; rotPre <= '0;
      end else if (!rotating) begin
         primary <= '0; rotCnt <= '0; rotPre <= '0;
      end else if (rotPre != 16'(ROT_CYCLES_PER_UNIT - 1)) begin
         rotPre <= rotPre + 16'h0001;
      end else begin
         rotPre <= '0;
         if (rotCnt + TMR_W'(1) >= rotPeriod) begin
            rotCnt <= '0;
            primary <= (primary >= auxEff) ? '0 : primary + AUX_W'(1); // RULE18
         end else begin
            rotCnt <= rotCnt + TMR_W'(1);
         end
      end
   end

   // Unit at a given position of the staging order; 0 is the master
   function automatic logic [AUX_W-1:0] unitAt(input logic [AUX_W-1:0] pos,
                                               input logic [AUX_W-1:0] prim,
                                               input logic [AUX_W-1:0] n);
      logic [AUX_W:0] u;
      u = '0;
      if (prim == '0) begin
         u = {1'b0, pos};
      end else if (pos == '0) begin
         u = {1'b0, prim}; // RULE13
      end else if (pos == AUX_W'(1)) begin
         u = '0; // RULE19
      end else begin
         u = {1'b0, prim} + {1'b0, pos} - (AUX_W+1)'(1); // RULE20
         if (u > {1'b0, n}) u = u - {1'b0, n};
      end
      return u[AUX_W-1:0];
   endfunction : unitAt

   // ---------------------------------------------------------------
   // Staging sequencer
   // ---------------------------------------------------------------
   llp_state_t       state;
   logic [AUX_W-1:0] depth;   // units beyond the first that are running
   logic [TMR_W-1:0] stgCnt, dstCnt, holdCnt;
   logic [AUX_W:0]   maxDepth;
   logic             lowCond, highCond, winCond, stgGo, dstGo, primRun;

   assign maxDepth = rotating ? {1'b0, auxEff} : {1'b0, auxEff};
   assign lowCond  = {1'b0, pv} <= {1'b0, target} - {1'b0, stgOfs}
                     && target >= stgOfs; // RULE5
   assign highCond = {1'b0, pv} >= {1'b0, target} + {1'b0, dstOfs}; // RULE10
   assign winCond  = spd >= minSpd && {1'b0, spd} <= {1'b0, minSpd} + {1'b0, dstWin}; // RULE12
   // The primary unit itself needs no wait when it is idle
   assign stgGo    = lowCond && (stgCnt >= stgWait || (rotating && !primRun)); // RULE6 RULE21
   assign dstGo    = highCond && winCond && dstCnt >= dstWait && depth != '0; // RULE11

   // Restarts after every stage, so units come in one wait apart
   always_ff @(posedge clk_sys) begin
      if (rst || !lowCond || stgGo || state != LLP_RUN) stgCnt <= '0; // RULE24
      else if (stgCnt != {TMR_W{1'b1}}) stgCnt <= stgCnt + TMR_W'(1);
   end

   always_ff @(posedge clk_sys) begin
      if (rst || !highCond || !winCond || state != LLP_RUN) dstCnt <= '0; // RULE24
      else if (dstCnt != {TMR_W{1'b1}}) dstCnt <= dstCnt + TMR_W'(1);
   end

   always_ff @(posedge clk_sys) begin
      if (rst || !staging) begin
         state   <= LLP_RUN;
         depth   <= '0;
         holdCnt <= '0;
         primRun <= 1'b0;
      end else begin
         unique case (state)
            LLP_RUN: begin
               if (rotating && !primRun) begin
                  if (stgGo) primRun <= 1'b1; // RULE13 RULE21
               end else if (stgGo && {1'b0, depth} < maxDepth) begin
                  depth <= depth + AUX_W'(1); // RULE4 RULE14
               end else if (dstGo) begin
                  depth <= depth - AUX_W'(1); // RULE7 RULE23
                  state <= LLP_BOOST;
                  holdCnt <= '0;
               end
            end
            LLP_BOOST: begin
               if (holdCnt + TMR_W'(1) >= holdTime) state <= LLP_RUN; // RULE9
               else holdCnt <= holdCnt + TMR_W'(1);
            end
         endcase
         if (!rotating) primRun <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic [DRV_W-1:0] runVec;
   always_comb begin
      runVec = '0;
      if (staging) begin
         if (primRun || !rotating) runVec[unitAt('0, primary, auxEff)] = 1'b1;
         for (int p = 1; p <= MAX_AUX_LINK; p++) begin
            if (AUX_W'(p) <= depth) runVec[unitAt(AUX_W'(p), primary, auxEff)] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         relayOut <= '0; drive <= '0; masterRun <= 1'b0;
      end else begin
         // Relay k follows auxiliary k; other functions lose the relays
         relayOut <= staging ? runVec[RELAY_W:1] : relayFuncIn; // RULE3 RULE17
         drive.runCmd <= runVec;
         masterRun <= staging ? runVec[0] : 1'b1;
         drive.speedOverride <= state == LLP_BOOST;
         drive.speedCmd <= minSpd + boost; // RULE8
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   // One map for reads and for masked writes, so the two cannot drift
   function automatic logic [31:0] regRead(input logic [31:0] a);
      logic [31:0] r;
      unique case (a)
         ADDR_CTRL:     r = ctrlWord;
         ADDR_TARGET:   r = {16'h0, target};
         ADDR_STG_OFS:  r = {16'h0, stgOfs};
         ADDR_DST_OFS:  r = {16'h0, dstOfs};
         ADDR_STG_WAIT: r = {8'h0, stgWait};
         ADDR_DST_WAIT: r = {8'h0, dstWait};
         ADDR_MIN_SPD:  r = {16'h0, minSpd};
         ADDR_DST_WIN:  r = {16'h0, dstWin};
         ADDR_BOOST:    r = {16'h0, boost};
         ADDR_HOLD:     r = {8'h0, holdTime};
         ADDR_ROT:      r = {8'h0, rotPeriod};
         ADDR_FILL:     r = {16'h0, fillLim};
         ADDR_STATUS:   r = {10'h0, runVec, 5'h0, primary, depth, state == LLP_BOOST,
                             1'b0, primRun, rotating, staging};
         ADDR_PV:       r = {spd, pv};
         default:       r = '0;
      endcase
      return r;
   endfunction : regRead

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= regRead(s_axi_araddr);
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // Fill limit below target is the programmer's duty; stored only RULE22
endmodule : llp_staging
`default_nettype wire

// >>> tb/llp_pump_model.sv
// Pump bank model: auxiliary run inputs and master speed feedback
`timescale 1ns/1ps
`default_nettype none
module llp_pump_model (
   input  wire logic                        clk_sys,
   input  wire logic [llp_pkg::RELAY_W-1:0] relayOut,
   input  wire llp_pkg::llp_drive_t         drive,
   input  wire logic [llp_pkg::VAL_W-1:0]   baseSpeed,
   output var  logic [llp_pkg::VAL_W-1:0]   masterSpeed,
   output var  logic [2:0]                  pumpsOn
);
   import llp_pkg::*;
   // Feedback follows the boost, so the window test sees the boosted drive
   always_ff @(posedge clk_sys) begin
      masterSpeed <= drive.speedOverride ? drive.speedCmd : baseSpeed;
      pumpsOn     <= 3'($countones(relayOut));
   end
endmodule : llp_pump_model
`default_nettype wire

// >>> tb/llp_staging_properties.sv
// Port-level assertions for the pump staging sequencer
`timescale 1ns/1ps
`default_nettype none
module llp_staging_properties #(
   parameter int ROT_CYCLES_PER_UNIT = 1
) (
   input wire logic                        clk_sys,
   input wire logic                        rst,
   input wire logic [llp_pkg::RELAY_W-1:0] relayFuncIn,
   input wire logic [llp_pkg::RELAY_W-1:0] relayOut,
   input wire llp_pkg::llp_drive_t         drive,
   input wire logic                        masterRun,
   input wire logic                        s_axi_awready,
   input wire logic                        s_axi_bvalid,
   input wire logic                        s_axi_bready,
   input wire logic [1:0]                  s_axi_bresp,
   input wire logic                        s_axi_arvalid,
   input wire logic                        s_axi_arready,
   input wire logic                        s_axi_rvalid,
   input wire logic                        s_axi_rready,
   input wire logic [31:0]                 s_axi_rdata
);
   import llp_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_reset_clear: assert property (disable iff (1'b0)
      rst |=> relayOut == '0 && drive.runCmd == '0 && !masterRun)
      else $error("outputs not cleared by reset");
   a_relay_source: assert property (
      relayOut == '0 || relayOut == drive.runCmd[3:1] || relayOut == $past(relayFuncIn))
      else $error("relay output has no valid source");
   a_master_second: assert property (
      $countones(drive.runCmd[DRV_W-1:1]) >= 2 |-> masterRun)
      else $error("two auxiliaries run without the master");
   a_boost_steady: assert property (
      drive.speedOverride && $past(drive.speedOverride) |-> $stable(drive.speedCmd))
      else $error("boost speed moved during hold");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address ready longer than one cycle");
   a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("read address ready longer than one cycle");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule : llp_staging_properties
bind llp_staging llp_staging_properties #(.ROT_CYCLES_PER_UNIT(ROT_CYCLES_PER_UNIT))
   llp_staging_properties_i (.clk_sys(clk_sys), .rst(rst), .relayFuncIn(relayFuncIn),
   .relayOut(relayOut), .drive(drive), .masterRun(masterRun), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// >>> tb/test_llp_staging.sv
// Self-checking bench for the pump staging sequencer
`timescale 1ns/1ps
`default_nettype none
module test_llp_staging;
   import llp_pkg::*;
   logic               clk_sys = 1'b0;
   logic               rst = 1'b1;
   logic [VAL_W-1:0]   processValue = 16'h03E8;
   logic [VAL_W-1:0]   baseSpeed = 16'h0190;
   logic [VAL_W-1:0]   masterSpeed;
   logic [RELAY_W-1:0] relayFuncIn = 3'h5;
   logic [RELAY_W-1:0] relayOut;
   llp_drive_t         drive;
   logic               masterRun;
   logic [2:0]         pumpsOn;
   logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, awready, wready, bvalid;
   logic               arvalid = 1'b0, rready = 1'b0, arready, rvalid;
   logic [31:0]        awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic [1:0]         bresp, rresp;
   int                 fail_count = 0;
   int                 samples_checked = 0;

   always #50 clk_sys = ~clk_sys;

   llp_staging llp_staging_i (.clk_sys(clk_sys), .rst(rst), .processValue(processValue),
      .masterSpeed(masterSpeed), .relayFuncIn(relayFuncIn), .relayOut(relayOut),
      .drive(drive), .masterRun(masterRun), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
   llp_pump_model llp_pump_model_i (.clk_sys(clk_sys), .relayOut(relayOut), .drive(drive),
      .baseSpeed(baseSpeed), .masterSpeed(masterSpeed), .pumpsOn(pumpsOn));

   // --------------------------------
   // Bus cycles and comparison
   // --------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 50);
      bready <= 1'b0;
      chk(32'(n < 50), 32'h1);
      chk({30'h0, bresp}, {30'h0, er});
   endtask : axw

   task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 50);
      rready <= 1'b0;
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : axr

   task automatic waitRelay(input logic [2:0] want, output int n);
      n = 0;
      while (relayOut !== want && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
   endtask : waitRelay

   // --------------------------------
   // Scenarios
   // --------------------------------
   task automatic t_registers();
      logic [31:0] regA [10] = '{ADDR_TARGET, ADDR_STG_OFS, ADDR_DST_OFS, ADDR_STG_WAIT,
         ADDR_DST_WAIT, ADDR_MIN_SPD, ADDR_DST_WIN, ADDR_BOOST, ADDR_HOLD, ADDR_FILL};
      logic [31:0] regD [10] = '{32'h3E8, 32'h32, 32'h3C, 32'h14, 32'h0F, 32'h12C, 32'h28,
         32'h50, 32'h0C, 32'h384};
      for (int i = 0; i < 10; i++) begin
         axw(regA[i], regD[i], RESP_OKAY);
         axr(regA[i], regD[i], RESP_OKAY);
      end
      axw(ADDR_STATUS, 32'h1, RESP_SLVERR);
      axw(32'h0000_0040, 32'h1, RESP_SLVERR);
      axr(32'h0000_0040, 32'h0, RESP_SLVERR);
   endtask : t_registers

   task automatic t_enable();
      chk({29'h0, relayOut}, 32'h5);
      chk({31'h0, masterRun}, 32'h1);
      axw(ADDR_CTRL, 32'h3, RESP_OKAY);
      axr(ADDR_CTRL, 32'h3, RESP_OKAY);
      relayFuncIn <= 3'h7;
      repeat (4) @(posedge clk_sys);
      chk({29'h0, relayOut}, 32'h0);
   endtask : t_enable

   task automatic t_stage();
      int n;
      processValue <= 16'h03B7;
      repeat (60) @(posedge clk_sys);
      chk({29'h0, relayOut}, 32'h0);
      processValue <= 16'h03B6;
      repeat (15) @(posedge clk_sys);
      processValue <= 16'h03E8;
      repeat (3) @(posedge clk_sys);
      processValue <= 16'h03B6;
      repeat (15) @(posedge clk_sys);
      processValue <= 16'h03E8;
      repeat (40) @(posedge clk_sys);
      chk({29'h0, relayOut}, 32'h0);
      processValue <= 16'h03B6;
      waitRelay(3'h1, n);
      chk(32'(n >= 20 && n <= 30), 32'h1);
      waitRelay(3'h3, n);
      processValue <= 16'h03E8;
      chk(32'(n >= 15 && n <= 25), 32'h1);
      repeat (60) @(posedge clk_sys);
      chk({29'h0, relayOut}, 32'h3);
      chk({29'h0, drive.runCmd[3:1]}, 32'h3);
      chk({29'h0, pumpsOn}, 32'h2);
   endtask : t_stage

   task automatic t_destage();
      int n;
      processValue <= 16'h0424;
      repeat (60) @(posedge clk_sys);
      chk({29'h0, relayOut}, 32'h3);
      baseSpeed <= 16'h0154;
      waitRelay(3'h1, n);
      chk(32'(n >= 15 && n <= 27), 32'h1);
      n = 0;
      while (drive.speedOverride !== 1'b1 && n < 10) begin
         @(posedge clk_sys);
         n++;
      end
      processValue <= 16'h03E8;
      chk({29'h0, relayOut}, 32'h1);
      chk({16'h0, drive.speedCmd}, 32'h17C);
      n = 0;
      while (drive.speedOverride === 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(n), 32'hC);
   endtask : t_destage

   task automatic t_rotate();
      int n;
      axw(ADDR_ROT, 32'hA, RESP_OKAY);
      axw(ADDR_CTRL, 32'h13, RESP_OKAY);
      waitRelay(3'h2, n);
      chk(32'(n < 400), 32'h1);
      chk({26'h0, drive.runCmd}, 32'h5);
      waitRelay(3'h4, n);
      chk(32'(n < 400), 32'h1);
      chk({26'h0, drive.runCmd}, 32'h9);
   endtask : t_rotate

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      t_registers();
      t_enable();
      t_stage();
      t_destage();
      t_rotate();
      test_done();
   end

   // Whole run is under a thousand cycles; this cap cuts a hang short
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      test_done();
   end
endmodule : test_llp_staging
`default_nettype wire
